/* rtl/spi_cfg_pkg.sv */
package spi_cfg_pkg;
  // Frame layout
  localparam int          INSTR_W       = 16;
  localparam int          ADDR_W        = 13;
  localparam int          INSTR_RD_BIT  = 15;
  localparam int          INSTR_WL_HI   = 14;
  localparam int          INSTR_WL_LO   = 13;
  localparam logic [1:0]  WL_STREAM     = 2'b11;
  // Register map
  localparam logic [12:0] ADDR_PORT_CFG = 13'h000;
  localparam logic [12:0] ADDR_CHIP_ID  = 13'h001;
  localparam logic [12:0] ADDR_CHAN     = 13'h005;
  localparam logic [12:0] ADDR_XFER     = 13'h0ff;
  localparam logic [12:0] CFG_BASE      = 13'h008;
  localparam logic [7:0]  XFER_GO       = 8'h01;
  localparam logic [1:0]  CHAN_RESET    = 2'b11;
  // Port configuration fields, mirrored nibbles
  localparam int          PCFG_LSB_HI   = 6;
  localparam int          PCFG_LSB_LO   = 1;
  localparam int          PCFG_SRST_HI  = 5;
  localparam int          PCFG_SRST_LO  = 2;
  localparam logic [7:0]  PCFG_FIXED    = 8'h18;
  // Timing
  localparam int          CLK_NS        = 10;
  localparam int          SCLK_HALF_NS  = 60;
  localparam int          SCLK_HALF_CYC = SCLK_HALF_NS / CLK_NS;

  typedef enum logic {
    PH_INSTR = 1'b0,
    PH_DATA  = 1'b1
  } phase_t;

  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_SETUP = 3'b001,
    H_LOW   = 3'b010,
    H_HIGH  = 3'b011,
    H_STALL = 3'b100,
    H_END   = 3'b101,
    H_GAP   = 3'b110
  } hstate_t;

  // Bit of a byte sent at serial position n
  function automatic logic pick_bit(input logic [7:0] b, input logic [2:0] n,
                                    input logic lsb);
    pick_bit = lsb ? b[n] : b[3'd7 - n];
  endfunction

  // Byte after one more bit has been shifted in
  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic d,
                                          input logic lsb);
    shift_in = lsb ? {d, sh[7:1]} : {sh[6:0], d};
  endfunction
endpackage

/* rtl/spi_link_if.sv */
`timescale 1ns/1ns
interface spi_link_if;
  logic sclk;
  logic chip_select_n;
  logic host_sdo;
  logic host_oe;
  logic dev_sdo;
  logic dev_oe;
  logic sdio;

  // Shared data line with pull-up when nobody drives
  assign sdio = host_oe ? host_sdo : (dev_oe ? dev_sdo : 1'b1);

  modport host (
    output sclk,
    output chip_select_n,
    output host_sdo,
    output host_oe,
    input  sdio
  );

  modport device (
    input  sclk,
    input  chip_select_n,
    input  sdio,
    output dev_sdo,
    output dev_oe
  );
endinterface

/* rtl/serial_config_port.sv */
`timescale 1ns/1ns
// Function
// - Select low, then clock rise starts frame
// - Transfers proceed only while select low
// - Select held low streams consecutive frames
// - Select high between bytes resumes transfer, except in streaming data where it aborts
// - Select high releases pins, secondary functions
// - Frame opens with sixteen-bit instruction
// - Word-length bits set data byte count
// - Data moves in bytes; registers are bytes
// - First bit (last bit when LSB first) selects read or write
// - Read turns data line around to output
// - Data line input during writes; clock, select inputs
// - Clock edges time shifting in and out
// - MSB first default; LSB first selectable
// - Host keeps port idle during sampling
// - Transfer write applies staged values, self-clears
// - Channel bits select; both read channel A
module serial_config_port
  import spi_cfg_pkg::*;
#(
  parameter int         CFG_NUM = 16,
  parameter logic [7:0] CHIP_ID = 8'h5c  // Arbitrary identity value
) (
  // System
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  // Serial link
  spi_link_if.device                    link,
  // Applied configuration
  output logic [CFG_NUM-1:0][7:0]       cfg_a,
  output logic [CFG_NUM-1:0][7:0]       cfg_b,
  // Port status
  output logic                          lsb_first,
  output logic                          port_idle
);

  typedef struct packed {
    logic                     sclk_m;
    logic                     sclk_s;
    logic                     sclk_d;
    logic                     csn_m;
    logic                     csn_s;
    logic                     sdi_m;
    logic                     sdi_s;
    phase_t                   phase;
    logic                     ibyte;
    logic [2:0]               bit_cnt;
    logic [7:0]               sh;
    logic [7:0]               b0;
    logic [7:0]               tx;
    logic                     rd;
    logic [1:0]               wlen;
    logic [1:0]               left;
    logic [ADDR_W-1:0]        addr;
    logic                     drive;
    logic                     sdo;
    logic                     lsb;
    logic [1:0]               chan;
    logic [CFG_NUM-1:0][7:0]  stg_a;
    logic [CFG_NUM-1:0][7:0]  stg_b;
    logic [CFG_NUM-1:0][7:0]  act_a;
    logic [CFG_NUM-1:0][7:0]  act_b;
  } st_t;

  st_t                  s_reg;
  st_t                  s_next;
  logic                 rise;
  logic [7:0]           nb;
  logic [INSTR_W-1:0]   instr;
  logic [ADDR_W-1:0]    addr_step;

  function automatic logic cfg_hit(input logic [ADDR_W-1:0] a);
    cfg_hit = (int'(a) >= int'(CFG_BASE)) && (int'(a) < int'(CFG_BASE) + CFG_NUM);
  endfunction

  function automatic int cfg_idx(input logic [ADDR_W-1:0] a);
    cfg_idx = int'(a) - int'(CFG_BASE);
  endfunction

  function automatic logic [7:0] read_byte(input logic [ADDR_W-1:0] a, input st_t s);
    logic [7:0] v;
    v = 8'h00;
    if (a == ADDR_PORT_CFG) begin
      v = PCFG_FIXED;
      v[PCFG_LSB_HI] = s.lsb;
      v[PCFG_LSB_LO] = s.lsb;
    end else if (a == ADDR_CHIP_ID) begin
      v = CHIP_ID;
    end else if (a == ADDR_CHAN) begin
      v = {6'h00, s.chan};
    end else if (cfg_hit(a)) begin
      v = (s.chan[0] || !s.chan[1]) ? s.stg_a[cfg_idx(a)] : s.stg_b[cfg_idx(a)];
    end
    read_byte = v;
  endfunction

  assign rise      = s_reg.sclk_s & ~s_reg.sclk_d;
  assign nb        = shift_in(s_reg.sh, s_reg.sdi_s, s_reg.lsb);
  assign instr     = s_reg.lsb ? {nb, s_reg.b0} : {s_reg.b0, nb};
  assign addr_step = s_reg.lsb ? s_reg.addr + 13'd1 : s_reg.addr - 13'd1;

  always_comb begin
    s_next        = s_reg;
    s_next.sclk_m = link.sclk;
    s_next.sclk_s = s_reg.sclk_m;
    s_next.sclk_d = s_reg.sclk_s;
    s_next.csn_m  = link.chip_select_n;
    s_next.csn_s  = s_reg.csn_m;
    s_next.sdi_m  = link.sdio;
    s_next.sdi_s  = s_reg.sdi_m;
    s_next.sdo    = pick_bit(s_reg.tx, s_reg.bit_cnt, s_reg.lsb);
    if (s_reg.csn_s) begin
      s_next.drive = 1'b0;
      // Mid-byte rise aborts, as does any rise in streaming data; other between-byte rise only stalls
      if (s_reg.bit_cnt != 3'd0 ||
          (s_reg.phase == PH_DATA && s_reg.wlen == WL_STREAM)) begin
        s_next.phase   = PH_INSTR;
        s_next.bit_cnt = 3'd0;
        s_next.ibyte   = 1'b0;
      end
    end else begin
      // Turn the line only after a low clock phase inside read data
      s_next.drive = (s_reg.phase == PH_DATA) & s_reg.rd &
                     (s_reg.drive | ~s_reg.sclk_s);
      if (rise) begin
        s_next.sh      = nb;
        s_next.bit_cnt = s_reg.bit_cnt + 3'd1;
        if (s_reg.bit_cnt == 3'd7) begin
          if (s_reg.phase == PH_INSTR) begin
            if (!s_reg.ibyte) begin
              s_next.b0    = nb;
              s_next.ibyte = 1'b1;
            end else begin
              s_next.ibyte = 1'b0;
              s_next.rd    = instr[INSTR_RD_BIT];
              s_next.wlen  = instr[INSTR_WL_HI:INSTR_WL_LO];
              s_next.left  = instr[INSTR_WL_HI:INSTR_WL_LO];
              s_next.addr  = instr[ADDR_W-1:0];
              s_next.phase = PH_DATA;
              s_next.tx    = read_byte(instr[ADDR_W-1:0], s_reg);
            end
          end else begin
            if (!s_reg.rd) begin
              if (s_reg.addr == ADDR_PORT_CFG) begin
                s_next.lsb = nb[PCFG_LSB_HI] | nb[PCFG_LSB_LO];
                if (nb[PCFG_SRST_HI] | nb[PCFG_SRST_LO]) begin
                  s_next.lsb   = 1'b0;
                  s_next.chan  = CHAN_RESET;
                  s_next.stg_a = '0;
                  s_next.stg_b = '0;
                end
              end else if (s_reg.addr == ADDR_CHAN) begin
                s_next.chan = nb[1:0];
              end else if (s_reg.addr == ADDR_XFER) begin
                if ((nb & XFER_GO) != 8'h00) begin
                  s_next.act_a = s_reg.stg_a;
                  s_next.act_b = s_reg.stg_b;
                end
              end else if (cfg_hit(s_reg.addr)) begin
                if (s_reg.chan[0]) begin
                  s_next.stg_a[cfg_idx(s_reg.addr)] = nb;
                end
                if (s_reg.chan[1]) begin
                  s_next.stg_b[cfg_idx(s_reg.addr)] = nb;
                end
              end
            end
            s_next.addr = addr_step;
            s_next.tx   = read_byte(addr_step, s_next);
            if (s_reg.wlen != WL_STREAM) begin
              if (s_reg.left == 2'd0) begin
                s_next.phase = PH_INSTR;
              end else begin
                s_next.left = s_reg.left - 2'd1;
              end
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_reg       <= '0;
      s_reg.csn_m <= 1'b1;
      s_reg.csn_s <= 1'b1;
      s_reg.sdi_m <= 1'b1;
      s_reg.sdi_s <= 1'b1;
      s_reg.chan  <= CHAN_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.dev_sdo = s_reg.sdo;
  assign link.dev_oe  = s_reg.drive;
  assign cfg_a        = s_reg.act_a;
  assign cfg_b        = s_reg.act_b;
  assign lsb_first    = s_reg.lsb;
  assign port_idle    = s_reg.csn_s;

endmodule // serial_config_port

/* rtl/serial_config_host.sv */
`timescale 1ns/1ns
module serial_config_host
  import spi_cfg_pkg::*;
#(
  parameter int HALF_CYC = SCLK_HALF_CYC
) (
  // System
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // Serial link
  spi_link_if.host                 link,
  // Command
  input  wire logic                cmd_valid,
  output logic                     cmd_ready,
  input  wire logic                cmd_read,
  input  wire logic [1:0]          cmd_wlen,
  input  wire logic [ADDR_W-1:0]   cmd_addr,
  input  wire logic [31:0]         cmd_wdata,
  input  wire logic                lsb_first,
  input  wire logic                stall_en,
  // Response
  output logic                     rsp_done,
  output logic [31:0]              rsp_rdata
);

  localparam logic [7:0] HALF_M1 = 8'(HALF_CYC - 1);

  typedef struct packed {
    hstate_t            st;
    logic [7:0]         cnt;
    logic [2:0]         bitn;
    logic [2:0]         idx;
    logic               rd;
    logic               lsb;
    logic               stall;
    logic [1:0]         wlen;
    logic [ADDR_W-1:0]  addr;
    logic [31:0]        wd;
    logic [31:0]        rdat;
    logic               sclk;
    logic               csn;
    logic               sdo;
    logic               oe;
    logic               sdi_m;
    logic               sdi_s;
    logic               done;
  } hst_t;

  hst_t        s_reg;
  hst_t        s_next;
  logic [2:0]  last_idx;
  logic [1:0]  dbyte;

  // Byte on the wire at position i: two instruction bytes, then data bytes
  function automatic logic [7:0] wire_byte(input hst_t s, input logic [2:0] i);
    logic [INSTR_W-1:0] ins;
    logic [1:0]         k;
    ins = {s.rd, s.wlen, s.addr};
    k   = 2'(i - 3'd2);
    if (i == 3'd0) begin
      wire_byte = s.lsb ? ins[7:0] : ins[15:8];
    end else if (i == 3'd1) begin
      wire_byte = s.lsb ? ins[15:8] : ins[7:0];
    end else begin
      wire_byte = s.wd[{k, 3'b000} +: 8];
    end
  endfunction

  function automatic logic host_drives(input hst_t s, input logic [2:0] i);
    host_drives = !(s.rd && i >= 3'd2);
  endfunction

  assign last_idx = (s_reg.wlen == WL_STREAM) ? 3'd5 : 3'({1'b0, s_reg.wlen}) + 3'd2;
  assign dbyte    = 2'(s_reg.idx - 3'd2);

  always_comb begin
    s_next       = s_reg;
    s_next.sdi_m = link.sdio;
    s_next.sdi_s = s_reg.sdi_m;
    s_next.done  = 1'b0;
    unique case (s_reg.st)
      H_IDLE: begin
        if (cmd_valid) begin
          s_next.rd    = cmd_read;
          s_next.wlen  = cmd_wlen;
          s_next.addr  = cmd_addr;
          s_next.wd    = cmd_wdata;
          s_next.lsb   = lsb_first;
          s_next.stall = stall_en;
          s_next.rdat  = 32'h0000_0000;
          s_next.bitn  = 3'd0;
          s_next.idx   = 3'd0;
          s_next.csn   = 1'b0;
          s_next.cnt   = HALF_M1;
          s_next.st    = H_SETUP;
        end
      end
      H_SETUP: begin
        if (s_reg.cnt == 8'h00) begin
          s_next.st  = H_LOW;
          s_next.cnt = HALF_M1;
          s_next.sdo = pick_bit(wire_byte(s_reg, s_reg.idx), s_reg.bitn, s_reg.lsb);
          s_next.oe  = host_drives(s_reg, s_reg.idx);
        end else begin
          s_next.cnt = s_reg.cnt - 8'h01;
        end
      end
      H_LOW: begin
        if (s_reg.cnt == 8'h00) begin
          s_next.st   = H_HIGH;
          s_next.cnt  = HALF_M1;
          s_next.sclk = 1'b1;
          if (!host_drives(s_reg, s_reg.idx)) begin
            s_next.rdat[{dbyte, s_reg.lsb ? s_reg.bitn : 3'd7 - s_reg.bitn}] = s_reg.sdi_s;
          end
        end else begin
          s_next.cnt = s_reg.cnt - 8'h01;
        end
      end
      H_HIGH: begin
        if (s_reg.cnt == 8'h00) begin
          s_next.sclk = 1'b0;
          s_next.cnt  = HALF_M1;
          s_next.bitn = s_reg.bitn + 3'd1;
          s_next.st   = H_LOW;
          if (s_reg.bitn == 3'd7) begin
            s_next.idx = s_reg.idx + 3'd1;
          end
          if (s_reg.bitn == 3'd7 && s_reg.idx == last_idx) begin
            s_next.st = H_END;
            s_next.oe = 1'b0;
          end else if (s_reg.bitn == 3'd7 && s_reg.stall && s_reg.wlen != WL_STREAM) begin
            s_next.st  = H_STALL;
            s_next.csn = 1'b1;
            s_next.oe  = 1'b0;
          end else begin
            s_next.sdo = pick_bit(wire_byte(s_reg, s_next.idx), s_next.bitn, s_reg.lsb);
            s_next.oe  = host_drives(s_reg, s_next.idx);
          end
        end else begin
          s_next.cnt = s_reg.cnt - 8'h01;
        end
      end
      H_STALL: begin
        if (s_reg.cnt == 8'h00) begin
          s_next.csn = 1'b0;
          s_next.cnt = HALF_M1;
          s_next.st  = H_SETUP;
        end else begin
          s_next.cnt = s_reg.cnt - 8'h01;
        end
      end
      H_END: begin
        if (s_reg.cnt == 8'h00) begin
          s_next.csn = 1'b1;
          s_next.cnt = HALF_M1;
          s_next.st  = H_GAP;
        end else begin
          s_next.cnt = s_reg.cnt - 8'h01;
        end
      end
      H_GAP: begin
        if (s_reg.cnt == 8'h00) begin
          s_next.done = 1'b1;
          s_next.st   = H_IDLE;
        end else begin
          s_next.cnt = s_reg.cnt - 8'h01;
        end
      end
      default: begin
        s_next.st  = H_IDLE;
        s_next.csn = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_reg       <= '0;
      s_reg.csn   <= 1'b1;
      s_reg.sdi_m <= 1'b1;
      s_reg.sdi_s <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign cmd_ready          = (s_reg.st == H_IDLE);
  assign link.sclk          = s_reg.sclk;
  assign link.chip_select_n = s_reg.csn;
  assign link.host_sdo      = s_reg.sdo;
  assign link.host_oe       = s_reg.oe;
  assign rsp_done           = s_reg.done;
  assign rsp_rdata          = s_reg.rdat;

endmodule // serial_config_host

/* sim/serial_config_port_checker.sv */
`timescale 1ns/1ns
module serial_config_port_checker (
  // System
  input wire logic clk,
  input wire logic sys_rst,
  // Link
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic host_sdo,
  input wire logic host_oe,
  input wire logic dev_sdo,
  input wire logic dev_oe,
  input wire logic sdio
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  property p_no_contention;
    !(host_oe && dev_oe);
  endproperty
  a_no_contention: assert property (p_no_contention)
    else $error("both ends drive the data line");
  property p_sel_gates_clock;
    chip_select_n |-> !sclk;
  endproperty
  a_sel_gates_clock: assert property (p_sel_gates_clock)
    else $error("shift clock moves while deselected");
  property p_host_oe_in_frame;
    host_oe |-> !chip_select_n;
  endproperty
  a_host_oe_in_frame: assert property (p_host_oe_in_frame)
    else $error("host drives data while deselected");
  property p_frame_start;
    $fell(chip_select_n) |-> !sclk [*4];
  endproperty
  a_frame_start: assert property (p_frame_start)
    else $error("clock rise too soon after select");
  property p_clk_high;
    $rose(sclk) |-> sclk [*6] ##1 !sclk;
  endproperty
  a_clk_high: assert property (p_clk_high)
    else $error("shift clock high phase length");
  property p_host_data_stable;
    sclk && host_oe |-> $stable(host_sdo);
  endproperty
  a_host_data_stable: assert property (p_host_data_stable)
    else $error("host data moves while clock high");
  property p_dev_turn_on;
    $rose(dev_oe) |-> !sclk && !chip_select_n;
  endproperty
  a_dev_turn_on: assert property (p_dev_turn_on)
    else $error("device turns line around at wrong point");
  property p_dev_release;
    chip_select_n [*6] |-> !dev_oe;
  endproperty
  a_dev_release: assert property (p_dev_release)
    else $error("device still drives after select high");
  property p_dev_data_steady;
    dev_oe && $past(dev_oe) && !sclk |-> $stable(dev_sdo);
  endproperty
  a_dev_data_steady: assert property (p_dev_data_steady)
    else $error("device data moves while clock low");

  c_read: cover property ($rose(dev_oe));
  c_frame_end: cover property ($rose(chip_select_n));
  c_write_bit: cover property (host_oe && $rose(sclk));
endmodule // serial_config_port_checker

/* sim/serial_config_port_tb.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module serial_config_port_tb;
  import spi_cfg_pkg::*;
  localparam logic [7:0] ID_VAL = 8'h3a;  // Arbitrary identity value
  logic             clk       = 1'h0;
  logic             sys_rst   = 1'h1;
  logic             cmd_valid = 1'h0;
  logic             cmd_read  = 1'h0;
  logic             host_lsb  = 1'h0;
  logic             stall_en  = 1'h0;
  logic [1:0]       cmd_wlen  = 2'h0;
  logic [12:0]      cmd_addr  = 13'h000;
  logic [31:0]      cmd_wdata = 32'h0;
  logic [31:0]      cap       = 32'h0;
  logic [31:0]      rd_val;
  logic [31:0]      rsp_rdata;
  logic             cmd_ready;
  logic             rsp_done;
  logic             lsb_first;
  logic             port_idle;
  logic             port_idle2;
  logic [15:0][7:0] cfg_a;
  logic [15:0][7:0] cfg_b;
  logic [15:0][7:0] cfg_a2;
  int               mismatches = 0;
  int               checks = 0;

  spi_link_if link ();
  spi_link_if link2 ();

  always #5 clk = ~clk;

  // Bits seen on the wire at each shift clock rise, latest in bit 0
  always @(posedge link.sclk) cap <= {cap[30:0], link.sdio};

  serial_config_port #(.CHIP_ID(ID_VAL)) serial_config_port_inst (
    .clk(clk), .sys_rst(sys_rst), .link(link), .cfg_a(cfg_a), .cfg_b(cfg_b),
    .lsb_first(lsb_first), .port_idle(port_idle));
  serial_config_port #(.CHIP_ID(ID_VAL)) serial_config_port_inst2 (
    .clk(clk), .sys_rst(sys_rst), .link(link2), .cfg_a(cfg_a2), .cfg_b(),
    .lsb_first(), .port_idle(port_idle2));
  serial_config_host serial_config_host_inst (
    .clk(clk), .sys_rst(sys_rst), .link(link), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_wlen(cmd_wlen),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .lsb_first(host_lsb),
    .stall_en(stall_en), .rsp_done(rsp_done), .rsp_rdata(rsp_rdata));
  serial_config_port_checker serial_config_port_checker_inst (
    .clk(clk), .sys_rst(sys_rst), .sclk(link.sclk), .chip_select_n(link.chip_select_n),
    .host_sdo(link.host_sdo), .host_oe(link.host_oe), .dev_sdo(link.dev_sdo),
    .dev_oe(link.dev_oe), .sdio(link.sdio));

  task automatic results;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  function automatic logic [15:0] ins(input logic rd, input logic [1:0] wl,
                                      input logic [12:0] a);
    return {rd, wl, a};
  endfunction

  function automatic logic [15:0] rev16(input logic [15:0] x);
    logic [15:0] r;
    for (int i = 0; i < 16; i++) r[i] = x[15-i];
    return r;
  endfunction

  task automatic cmd(input logic rd, input logic [1:0] wl, input logic [12:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    cmd_read = rd;
    cmd_wlen = wl;
    cmd_addr = a;
    cmd_wdata = wd;
    cmd_valid = 1'h1;
    while (cmd_ready !== 1'h1 && n < 50) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 50) begin
      mismatches++;
      results();
    end
    @(posedge clk);
    #1 cmd_valid = 1'h0;
    while (rsp_done !== 1'h1 && n < 4000) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 4000) begin
      mismatches++;
      results();
    end
    rd_val = rsp_rdata;
  endtask

  // Drives the first n bits of v on the second link, then deselects
  task automatic bang(input logic [23:0] v, input int n);
    link2.chip_select_n = 1'h0;
    link2.host_oe = 1'h1;
    // Shift clock of 125 ns, free of the system clock
    for (int i = 0; i < n; i++) begin
      link2.host_sdo = v[23-i];
      #62 link2.sclk = 1'h1;
      #63 link2.sclk = 1'h0;
    end
    repeat (6) @(posedge clk);
    #1 `CHK(port_idle2, 1'h0)
    link2.host_oe = 1'h0;
    link2.chip_select_n = 1'h1;
    repeat (12) @(posedge clk);
    #1 `CHK(port_idle2, 1'h1)
  endtask

  initial begin
    link2.sclk = 1'h0;
    link2.chip_select_n = 1'h1;
    link2.host_sdo = 1'h0;
    link2.host_oe = 1'h0;
    repeat (20) @(posedge clk);
    #1 sys_rst = 1'h0;
    `CHK(cfg_a[0], 8'h00)
    `CHK(port_idle, 1'h1)
    `CHK(link.sdio, 1'h1)
    `CHK(lsb_first, 1'h0)
    cmd(1'h1, 2'h0, ADDR_CHIP_ID, 32'h0);
    `CHK(rd_val[7:0], ID_VAL)
    `CHK(cap[23:0], {ins(1'h1, 2'h0, ADDR_CHIP_ID), ID_VAL})
    `CHK(link.sdio, 1'h1)
    `CHK(link.sclk, 1'h0)
    `CHK(link.chip_select_n, 1'h1)
    cmd(1'h0, 2'h0, CFG_BASE, 32'ha5);
    `CHK(cap[23:0], {ins(1'h0, 2'h0, CFG_BASE), 8'ha5})
    `CHK(cfg_a[0], 8'h00)
    cmd(1'h1, 2'h0, CFG_BASE, 32'h0);
    `CHK(rd_val[7:0], 8'ha5)
    cmd(1'h0, 2'h0, ADDR_XFER, {24'h0, XFER_GO});
    `CHK(cfg_a[0], 8'ha5)
    `CHK(cfg_b[0], 8'ha5)
    cmd(1'h1, 2'h0, ADDR_XFER, 32'h0);
    `CHK(rd_val[7:0], 8'h00)
    // Each fixed word length, select raised between bytes
    stall_en = 1'h1;
    for (int w = 0; w < 3; w++) begin
      cmd(1'h0, w[1:0], 13'h00c, 32'h00c3b2a1 + w);
      cmd(1'h1, w[1:0], 13'h00c, 32'h0);
      `CHK(rd_val & ~(32'hffffffff << (8*w+8)), (32'h00c3b2a1 + w) & ~(32'hffffffff << (8*w+8)))
    end
    cmd(1'h1, 2'h0, 13'h00a, 32'h0);
    `CHK(rd_val[7:0], 8'hc3)
    stall_en = 1'h0;
    cmd(1'h0, WL_STREAM, 13'h017, 32'h44332211);
    cmd(1'h1, 2'h0, 13'h014, 32'h0);
    `CHK(rd_val[7:0], 8'h44)
    cmd(1'h1, WL_STREAM, 13'h017, 32'h0);
    `CHK(rd_val, 32'h44332211)
    // Per-channel copies of one byte
    cmd(1'h0, 2'h0, ADDR_CHAN, 32'h1);
    cmd(1'h0, 2'h0, CFG_BASE, 32'h3c);
    cmd(1'h0, 2'h0, ADDR_CHAN, 32'h2);
    cmd(1'h0, 2'h0, CFG_BASE, 32'hc3);
    cmd(1'h0, 2'h0, ADDR_XFER, {24'h0, XFER_GO});
    `CHK(cfg_a[0], 8'h3c)
    `CHK(cfg_b[0], 8'hc3)
    cmd(1'h0, 2'h0, ADDR_CHAN, {30'h0, CHAN_RESET});
    cmd(1'h1, 2'h0, CFG_BASE, 32'h0);
    `CHK(rd_val[7:0], 8'h3c)
    cmd(1'h0, 2'h0, 13'h100, 32'h77);
    cmd(1'h1, 2'h0, 13'h100, 32'h0);
    `CHK(rd_val[7:0], 8'h00)
    // Reversed shift order, then soft reset back to default
    cmd(1'h0, 2'h0, ADDR_PORT_CFG, 32'h42);
    `CHK(lsb_first, 1'h1)
    host_lsb = 1'h1;
    cmd(1'h1, 2'h0, ADDR_PORT_CFG, 32'h0);
    `CHK(rd_val[7:0], 8'h5a)
    cmd(1'h0, 2'h1, 13'h009, 32'hb2c1);
    `CHK(cap, {rev16(ins(1'h0, 2'h1, 13'h009)), rev16(16'hb2c1)})
    cmd(1'h1, 2'h0, 13'h00a, 32'h0);
    `CHK(rd_val[7:0], 8'hb2)
    cmd(1'h0, 2'h0, ADDR_PORT_CFG, 32'h24);
    `CHK(lsb_first, 1'h0)
    host_lsb = 1'h0;
    // Frames cut short, then whole frames, on the second link
    bang({ins(1'h0, 2'h0, CFG_BASE), 8'h99}, 10);
    bang({ins(1'h0, 2'h0, CFG_BASE), 8'h99}, 20);
    bang({ins(1'h0, 2'h0, ADDR_XFER), XFER_GO}, 24);
    `CHK(cfg_a2[0], 8'h00)
    bang({ins(1'h0, 2'h0, CFG_BASE), 8'h99}, 24);
    bang({ins(1'h0, 2'h0, ADDR_XFER), XFER_GO}, 24);
    `CHK(cfg_a2[0], 8'h99)
    results();
  end
endmodule // serial_config_port_tb
